// file: inc/cfsr_consts.vh
/*
 * constants for the configuration start-up and readout block.
 * assumes a single 40 MHz mclk; config, user and readout clocks are
 * sampled inputs, and configuration frames are written by other logic.
 */
`ifndef CFSR_CONSTS_VH
`define CFSR_CONSTS_VH
`define CFSR_LEN_W 24
`define CFSR_WAKE_W 5
`define CFSR_STG_FIRST 0
`define CFSR_STG_SECOND 1
`define CFSR_STG_FOURTH 3
`define CFSR_SEL_W 3
`define CFSR_SEL_DONE_DEF 3'h0
`define CFSR_SEL_IO_DEF 3'h1
`define CFSR_SEL_RST_DEF 3'h2
`define CFSR_DUMMY_BITS 4'h5
`define CFSR_CHECK_BITS 4'h4
`define CFSR_TAIL_HIGH 4'h7
`define CFSR_SIG_BITS 4'hB
`define CFSR_HEAD_HIGH 4'h2
`define CFSR_CRC_W 16
`define CFSR_CRC_POLY 16'h1021
`define CFSR_CRC_INIT 16'h0000
`define CFSR_FRM_BITS 8'h40
`define CFSR_FRM_CNT 4'h4
`define CFSR_FRM_AW 6
`define CFSR_FBIT_W 8
`endif

// file: rtl/cfsr_top.v
/*
 * end-of-configuration start-up sequencer and serial readout port.
 * assumes configuration frames are written into the local frame store by
 * the loader through cfg_wr_*, and that the config, user and readout
 * clocks arrive as slow external levels sampled by mclk.
 */
`timescale 1ns/1ps
`include "cfsr_consts.vh"
module cfsr_top
(
	input wire mclk,
	input wire arst_n,
	// configuration side
	input wire config_clock,
	input wire user_clock,
	input wire readout_clock,
	input wire cfg_active,
	input wire cfg_chain_mode,
	input wire cfg_master,
	input wire cfg_len_load,
	input wire [`CFSR_LEN_W-1:0] cfg_len_value,
	input wire cfg_mem_full,
	input wire cfg_wr_en,
	input wire [`CFSR_FRM_AW-1:0] cfg_wr_addr,
	input wire [`CFSR_FBIT_W-1:0] cfg_wr_data,
	// options held by the bitstream
	input wire [`CFSR_SEL_W-1:0] opt_sel_done,
	input wire [`CFSR_SEL_W-1:0] opt_sel_io,
	input wire [`CFSR_SEL_W-1:0] opt_sel_rst,
	input wire opt_userclk,
	input wire opt_wait_on_pin,
	input wire opt_pullup_off,
	input wire opt_capture,
	input wire opt_abort,
	input wire opt_rdclk_user,
	// done pin, open drain
	input wire done_pin_in,
	output wire done_pin_out,
	output wire done_pin_oe,
	output wire done_pullup_en,
	output reg master_clk_run,
	output reg io_active,
	output reg global_reset,
	// readout
	input wire readout_trigger,
	input wire [`CFSR_FBIT_W-1:0] capture_values,
	output reg readout_serial_out,
	output reg readout_in_progress
);
	// ****************************************************************
	// input synchronisers: three stages, a change counts when 2 and 3 agree
	// ****************************************************************
	localparam NSYNC = 5;
	wire [NSYNC-1:0] raw_in;
	reg [NSYNC-1:0] s1_q;
	reg [NSYNC-1:0] s2_q;
	reg [NSYNC-1:0] s3_q;
	reg [NSYNC-1:0] stable_q;
	wire [NSYNC-1:0] rise;
	wire [NSYNC-1:0] fall;
	assign raw_in = {readout_trigger, done_pin_in, readout_clock, user_clock, config_clock};
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi = gi + 1)
		begin : g_sync
			always @(posedge mclk or negedge arst_n)
			begin
				if (!arst_n)
				begin
					s1_q[gi] <= 1'b0;
					s2_q[gi] <= 1'b0;
					s3_q[gi] <= 1'b0;
					stable_q[gi] <= 1'b0;
				end
				else
				begin
					s1_q[gi] <= raw_in[gi];
					s2_q[gi] <= s1_q[gi];
					s3_q[gi] <= s2_q[gi];
					if (s2_q[gi] == s3_q[gi])
						stable_q[gi] <= s3_q[gi];
				end
			end
			assign rise[gi] = (s2_q[gi] == s3_q[gi]) && s3_q[gi] && !stable_q[gi];
			assign fall[gi] = (s2_q[gi] == s3_q[gi]) && !s3_q[gi] && stable_q[gi];
		end
	endgenerate
	wire config_clock_rise = rise[0];
	wire uclk_rise = rise[1];
	wire done_level = stable_q[3];
	wire trig_rise = rise[4];
	wire trig_fall = fall[4];

	// ****************************************************************
	// length counter and done condition
	// ****************************************************************
	reg [`CFSR_LEN_W-1:0] len_q;
	reg [`CFSR_LEN_W-1:0] clk_cnt_q;
	reg start_q;
	// counts from the very first config clock, preamble included
	wire [`CFSR_LEN_W-1:0] cnt_next = clk_cnt_q + {{(`CFSR_LEN_W-1){1'b0}}, 1'b1};
	// chain mode has no length count, memory full alone ends loading
	wire start_cond = cfg_mem_full && (cfg_chain_mode || clk_cnt_q == len_q);
	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			len_q <= {`CFSR_LEN_W{1'b0}};
			clk_cnt_q <= {`CFSR_LEN_W{1'b0}};
			start_q <= 1'b0;
			master_clk_run <= 1'b0;
		end
		else if (!cfg_active)
		begin
			clk_cnt_q <= {`CFSR_LEN_W{1'b0}};
			start_q <= 1'b0;
			master_clk_run <= 1'b0;
		end
		else
		begin
			if (cfg_len_load && !cfg_chain_mode)
				len_q <= cfg_len_value;
			if (config_clock_rise && !start_q)
				clk_cnt_q <= cnt_next;
			// a mismatch keeps a master clocking until the counter wraps back round
			master_clk_run <= cfg_master && !start_q && !start_cond;
			if (config_clock_rise && start_cond)
				start_q <= 1'b1;
		end
	end

	// ****************************************************************
	// five stage wake register
	// ****************************************************************
	reg [`CFSR_WAKE_W-1:0] wake_q;
	reg bridge_q;
	wire step_clk = opt_userclk ? uclk_rise : config_clock_rise;
	// holding the wired done pin low freezes the fourth stage and every stage beyond it
	wire pin_ok = !opt_wait_on_pin || done_level;
	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wake_q <= {`CFSR_WAKE_W{1'b0}};
			bridge_q <= 1'b0;
		end
		else if (!cfg_active)
		begin
			wake_q <= {`CFSR_WAKE_W{1'b0}};
			bridge_q <= 1'b0;
		end
		else
		begin
			// the edge that meets the start condition sets the first stage itself
			if (config_clock_rise && (start_q || start_cond))
				wake_q[`CFSR_STG_FIRST] <= 1'b1;
			// first stage lives on config clock; user clock picks it up one beat late
			if (opt_userclk && config_clock_rise)
				bridge_q <= wake_q[`CFSR_STG_FIRST];
			if (step_clk)
			begin
				wake_q[`CFSR_STG_SECOND] <= opt_userclk ? bridge_q : wake_q[`CFSR_STG_FIRST];
				wake_q[2] <= wake_q[`CFSR_STG_SECOND];
				if (pin_ok)
				begin
					wake_q[`CFSR_STG_FOURTH] <= wake_q[2];
					wake_q[4] <= wake_q[`CFSR_STG_FOURTH];
				end
			end
		end
	end

	// ****************************************************************
	// event mapping
	// ****************************************************************
	function stage_of;
		input [`CFSR_WAKE_W-1:0] w;
		input [`CFSR_SEL_W-1:0] s;
		begin
			stage_of = (s < `CFSR_WAKE_W) ? w[s] : w[`CFSR_WAKE_W-1];
		end
	endfunction
	wire done_rel = stage_of(wake_q, opt_sel_done);
	// done releases, io follows a clock later by default
	wire io_on = stage_of(wake_q, opt_sel_io);
	wire rst_off = stage_of(wake_q, opt_sel_rst);
	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			io_active <= 1'b0;
			global_reset <= 1'b1;
		end
		else
		begin
			io_active <= io_on;
			global_reset <= !rst_off;
		end
	end
	// open drain: only ever pulls low, rises through the pull-up
	assign done_pin_out = 1'b0;
	assign done_pin_oe = !done_rel;
	assign done_pullup_en = !opt_pullup_off;

	// ****************************************************************
	// frame store and readout
	// ****************************************************************
	reg [`CFSR_FBIT_W-1:0] mem [0:(1<<`CFSR_FRM_AW)-1];
	always @(posedge mclk)
	begin
		if (cfg_wr_en)
			mem[cfg_wr_addr] <= cfg_wr_data;
	end
	localparam RD_IDLE = 6'h01;
	localparam RD_DUMMY = 6'h02;
	localparam RD_START = 6'h04;
	localparam RD_DATA = 6'h08;
	localparam RD_SIG = 6'h10;
	localparam RD_ARM = 6'h20;
	reg [5:0] rd_st_q;
	reg [`CFSR_FBIT_W-1:0] bit_q;
	reg [3:0] frm_q;
	reg [3:0] cnt_q;
	reg [`CFSR_CRC_W-1:0] crc_q;
	reg [`CFSR_FBIT_W-1:0] cap_q;
	reg armed_q;
	wire rclk = opt_rdclk_user ? rise[2] : config_clock_rise;
	wire [`CFSR_FRM_AW-1:0] byte_addr = {frm_q[1:0], bit_q[6:3]};
	wire [`CFSR_FBIT_W-1:0] word = mem[byte_addr];
	wire last_frm = (frm_q == `CFSR_FRM_CNT - 4'h1);
	wire [`CFSR_FBIT_W-1:0] frm_end = `CFSR_FRM_BITS;
	// capture bits are the low byte of each frame and carry inverted state
	wire cap_zone = opt_capture && bit_q[6:3] == 4'h0;
	wire raw_bit = cap_zone ? ~cap_q[bit_q[2:0]] : word[bit_q[2:0]];
	wire force_hi = (frm_q == 4'h0 && bit_q < {4'h0, `CFSR_HEAD_HIGH}) ||
		(bit_q >= frm_end - {4'h0, `CFSR_CHECK_BITS}) ||
		(last_frm && bit_q >= frm_end - {4'h0, `CFSR_TAIL_HIGH});
	wire data_bit = force_hi | raw_bit;
	function [`CFSR_CRC_W-1:0] crc_step;
		input [`CFSR_CRC_W-1:0] c;
		input b;
		begin
			crc_step = {c[`CFSR_CRC_W-2:0], 1'b0} ^
				((c[`CFSR_CRC_W-1] ^ b) ? `CFSR_CRC_POLY : {`CFSR_CRC_W{1'b0}});
		end
	endfunction
	always @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rd_st_q <= RD_IDLE;
			bit_q <= {`CFSR_FBIT_W{1'b0}};
			frm_q <= 4'h0;
			cnt_q <= 4'h0;
			crc_q <= `CFSR_CRC_INIT;
			cap_q <= {`CFSR_FBIT_W{1'b0}};
			armed_q <= 1'b0;
			readout_serial_out <= 1'b1;
			readout_in_progress <= 1'b0;
		end
		else if (opt_abort && trig_fall && !rd_st_q[0])
		begin
			// abort drops out at once and disarms; no frame drain needed here
			rd_st_q <= RD_IDLE;
			armed_q <= 1'b0;
			readout_in_progress <= 1'b0;
			readout_serial_out <= 1'b1;
		end
		else
		begin
			if (trig_rise && rd_st_q[0])
			begin
				armed_q <= 1'b1;
				if (opt_capture)
					cap_q <= capture_values;
			end
			if (rclk)
			begin
				case (rd_st_q)
				RD_IDLE:
					if (armed_q)
					begin
						armed_q <= 1'b0;
						readout_in_progress <= 1'b1;
						rd_st_q <= RD_DUMMY;
						cnt_q <= 4'h0;
						frm_q <= 4'h0;
						crc_q <= `CFSR_CRC_INIT;
					end
				RD_DUMMY:
				begin
					readout_serial_out <= 1'b1;
					cnt_q <= cnt_q + 4'h1;
					if (cnt_q == `CFSR_DUMMY_BITS - 4'h1)
						rd_st_q <= RD_START;
				end
				RD_START:
				begin
					readout_serial_out <= 1'b0;
					bit_q <= {`CFSR_FBIT_W{1'b0}};
					cnt_q <= 4'h0;
					rd_st_q <= (frm_q == `CFSR_FRM_CNT) ? RD_SIG : RD_DATA;
				end
				RD_DATA:
				begin
					readout_serial_out <= data_bit;
					crc_q <= crc_step(crc_q, data_bit);
					bit_q <= bit_q + 8'h01;
					if (bit_q == frm_end - 8'h01)
					begin
						frm_q <= frm_q + 4'h1;
						rd_st_q <= RD_START;
					end
				end
				RD_SIG:
				begin
					readout_serial_out <= crc_q[`CFSR_CRC_W-1-cnt_q];
					cnt_q <= cnt_q + 4'h1;
					if (cnt_q == `CFSR_SIG_BITS - 4'h1)
						rd_st_q <= RD_ARM;
				end
				RD_ARM:
				begin
					readout_in_progress <= 1'b0;
					readout_serial_out <= 1'b1;
					rd_st_q <= RD_IDLE;
				end
				default:
					rd_st_q <= RD_IDLE;
				endcase
			end
		end
	end
endmodule // cfsr_top

// file: sim/cfsr_host.sv
/* far-side model: config and readout clocks and the wired done line.
   assumes mclk at 40 MHz; both slow clocks stand still unless enabled. */
`timescale 1ns/1ps
module cfsr_host
(
	input wire mclk,
	input wire cfg_go,
	input wire rd_go,
	input wire hold_done,
	input wire done_pin_oe,
	input wire done_pullup_en,
	output logic config_clock,
	output logic readout_clock,
	output wire done_pin_in
);
	logic [1:0] ph_q = 2'h0;
	initial
	begin
		config_clock = 1'b0;
		readout_clock = 1'b0;
	end
	// ************
	// 200 ns clocks
	// ************
	// skewed off the mclk edge so the block sees a foreign phase
	always @(posedge mclk)
	begin
		ph_q <= ph_q + 2'h1;
		if (ph_q == 2'h3)
		begin
			config_clock <= #7 cfg_go & ~config_clock;
			readout_clock <= #7 rd_go & ~readout_clock;
		end
	end
	// open drain: high only via the pull-up, low if anyone pulls
	assign done_pin_in = done_pullup_en & ~done_pin_oe & ~hold_done;
endmodule // cfsr_host

// file: sim/cfsr_top_monitor.sv
/* assertion checker for cfsr_top.
   assumes a single mclk domain; bound to every instance below. */
`timescale 1ns/1ps
`include "cfsr_consts.vh"
module cfsr_top_monitor
(
	input wire mclk,
	input wire arst_n,
	input wire cfg_active,
	input wire [`CFSR_SEL_W-1:0] opt_sel_done,
	input wire [`CFSR_SEL_W-1:0] opt_sel_io,
	input wire [`CFSR_SEL_W-1:0] opt_sel_rst,
	input wire opt_wait_on_pin,
	input wire opt_pullup_off,
	input wire opt_abort,
	input wire opt_rdclk_user,
	input wire readout_clock,
	input wire readout_trigger,
	input wire done_pin_in,
	input wire done_pin_out,
	input wire done_pin_oe,
	input wire done_pullup_en,
	input wire io_active,
	input wire global_reset,
	input wire readout_serial_out,
	input wire readout_in_progress
);
	// ************
	// properties
	// ************
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!arst_n);
	wire dflt = opt_sel_done == 3'h0 && opt_sel_io == 3'h1 && opt_sel_rst == 3'h2;
	sequence rd_quiet;
		(opt_rdclk_user && !readout_clock && readout_trigger) [*5];
	endsequence
	sequence pin_held;
		(opt_wait_on_pin && opt_sel_rst == 3'h3 && !done_pin_in) [*8];
	endsequence
	pullup_follows_a: assert property (done_pullup_en == !opt_pullup_off)
		else $error("pull-up enable wrong");
	drain_only_a: assert property (done_pin_out == 1'b0)
		else $error("done pin driven high");
	events_stand_a: assert property (cfg_active && io_active ##1 cfg_active |-> io_active)
		else $error("io enable withdrawn");
	io_after_done_a: assert property (dflt && $rose(io_active) |-> !$past(done_pin_oe, 4))
		else $error("io enabled before done release");
	rst_after_io_a: assert property (dflt && $fell(global_reset) |-> $past(io_active, 4))
		else $error("reset released before io enable");
	stall_a: assert property (pin_held |-> !$fell(global_reset))
		else $error("start-up advanced with done held low");
	rd_still_a: assert property (rd_quiet |-> $stable(readout_serial_out))
		else $error("readout data moved without a clock edge");
	rip_still_a: assert property (rd_quiet |-> $stable(readout_in_progress))
		else $error("readout busy moved without a clock edge");
	abort_a: assert property (opt_abort && readout_in_progress && $fell(readout_trigger)
		|-> ##[1:6] !readout_in_progress)
		else $error("abort did not end readout");
endmodule // cfsr_top_monitor
bind cfsr_top cfsr_top_monitor mon (.mclk, .arst_n, .cfg_active, .opt_sel_done, .opt_sel_io,
	.opt_sel_rst, .opt_wait_on_pin, .opt_pullup_off, .opt_abort, .opt_rdclk_user,
	.readout_clock, .readout_trigger, .done_pin_in, .done_pin_out, .done_pin_oe,
	.done_pullup_en, .io_active, .global_reset, .readout_serial_out, .readout_in_progress);

// file: sim/cfsr_top_test.sv
/* self-checking bench for cfsr_top: start-up order, done stall,
   readout stream and abort. assumes cfsr_host makes the slow clocks. */
`timescale 1ns/1ps
`include "cfsr_consts.vh"
module cfsr_top_test;
	logic mclk, arst_n, cfg_active, cfg_len_load, cfg_mem_full, cfg_wr_en, opt_wait_on_pin;
	logic opt_pullup_off, opt_abort, opt_rdclk_user, readout_trigger, cfg_go, rd_go, hold;
	logic cfg_master, opt_capture, cfg_chain_mode, opt_userclk;
	logic [23:0] cfg_len_value;
	logic [5:0] cfg_wr_addr;
	logic [7:0] cfg_wr_data, capture_values;
	logic [2:0] opt_sel_rst, opt_sel_done, opt_sel_io;
	wire config_clock, readout_clock, done_pin_in, done_pin_out, done_pin_oe, done_pullup_en;
	wire io_active, global_reset, readout_serial_out, readout_in_progress, master_clk_run;
	logic [7:0] mem [64];
	int errors = 0, comparisons = 0, cyc = 0;
	cfsr_top dut (.mclk, .arst_n, .config_clock, .user_clock(readout_clock), .readout_clock,
		.cfg_active, .cfg_chain_mode, .cfg_master, .cfg_len_load, .cfg_len_value,
		.cfg_mem_full, .cfg_wr_en, .cfg_wr_addr, .cfg_wr_data, .opt_sel_done,
		.opt_sel_io, .opt_sel_rst, .opt_userclk, .opt_wait_on_pin, .opt_pullup_off,
		.opt_capture, .opt_abort, .opt_rdclk_user, .done_pin_in, .done_pin_out,
		.done_pin_oe, .done_pullup_en, .master_clk_run, .io_active, .global_reset,
		.readout_trigger, .capture_values, .readout_serial_out, .readout_in_progress);
	cfsr_host host (.mclk, .cfg_go, .rd_go, .hold_done(hold), .done_pin_oe, .done_pullup_en,
		.config_clock, .readout_clock, .done_pin_in);
	// ************
	// helpers
	// ************
	initial
	begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			errors++;
			end_of_test();
		end
	end
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task end_of_test();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// six mclk after a slow edge lets the 3-stage sampler and outputs settle
	task automatic edge_wait(input logic usr);
		if (usr)
			@(posedge readout_clock);
		else
			@(posedge config_clock);
		repeat (6) @(posedge mclk);
	endtask
	task automatic reset_dut();
		arst_n <= 1'b0;
		{cfg_go, rd_go, readout_trigger, cfg_active, cfg_mem_full} <= 5'h00;
		repeat (6) @(posedge mclk);
		chk("reset", {done_pin_oe, io_active, global_reset, readout_serial_out,
			readout_in_progress}, 5'h16);
		arst_n <= 1'b1;
	endtask
	task automatic startup(input logic [2:0] srst, input logic hld, input logic alt,
		input logic [2:0] sio);
		int len, base;
		len = 8 + $urandom % 8;
		base = alt ? 0 : len;
		cfg_master <= !cfg_master;
		reset_dut();
		cfg_active <= 1'b1;
		cfg_len_value <= 24'(len);
		{cfg_len_load, opt_sel_rst, opt_wait_on_pin, hold, opt_pullup_off} <= {1'b1, srst, hld, hld, !hld};
		// alt: chain mode, later wake stages stepped by the user clock
		{cfg_chain_mode, opt_userclk, opt_sel_io} <= {alt, alt, sio};
		for (int i = 0; i < 64; i++)
		begin
			@(posedge mclk);
			cfg_len_load <= 1'b0;
			{cfg_wr_en, cfg_wr_addr, cfg_wr_data} <= {1'b1, 6'(i), mem[i]};
		end
		@(posedge mclk);
		{cfg_wr_en, cfg_mem_full, cfg_go, rd_go} <= {3'h3, alt};
		for (int k = 1; k <= base + 8; k++)
		begin
			edge_wait(0);
			chk("done_oe", done_pin_oe, k <= base);
			chk("master_run", master_clk_run, cfg_master && k < base);
			chk("io_active", io_active, k > base + sio + alt);
			chk("global_reset", global_reset, hld || k <= base + srst + alt);
		end
		hold <= 1'b0;
		repeat (2) edge_wait(0);
		chk("global_reset", global_reset, 1'b0);
		cfg_go <= 1'b0;
	endtask
	task automatic readout(input logic usr, input int nb, input logic cap);
		logic [15:0] crc;
		logic b;
		logic q[$];
		crc = 16'h0000;
		q = {1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
		for (int f = 0; f < 4; f++)
		begin
			q.push_back(1'b0);
			for (int n = 0; n < 64; n++)
			begin
				b = (cap && n < 8 ? ~capture_values[n] : mem[f * 16 + n / 8][n % 8]) |
					(f == 0 && n < 2) | n >= 60 | (f == 3 && n >= 57);
				q.push_back(b);
				crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ b) ? 16'h1021 : 16'h0000);
			end
		end
		q.push_back(1'b0);
		for (int i = 15; i > 4; i--)
			q.push_back(crc[i]);
		{opt_rdclk_user, opt_abort, opt_capture, readout_trigger} <= {usr, nb < q.size(), cap, 1'b1};
		repeat (6) @(posedge mclk);
		{rd_go, cfg_go} <= {usr, !usr};
		edge_wait(usr);
		chk("rip", readout_in_progress, 1'b1);
		for (int i = 0; i < q.size() && i < nb; i++)
		begin
			edge_wait(usr);
			chk("serial", readout_serial_out, q[i]);
		end
		if (nb < q.size())
		begin
			readout_trigger <= 1'b0;
			repeat (8) @(posedge mclk);
			chk("rip", readout_in_progress, 1'b0);
			readout_trigger <= 1'b1;
		end
		edge_wait(usr);
		chk("rip", readout_in_progress, nb < q.size());
	endtask
	// ************
	// main
	// ************
	initial
	begin
		{arst_n, cfg_active, cfg_len_load, cfg_mem_full, cfg_wr_en, opt_wait_on_pin} = 6'h00;
		{opt_pullup_off, opt_abort, opt_rdclk_user, readout_trigger, cfg_go, rd_go, hold} = 7'h00;
		{cfg_len_value, cfg_wr_addr, cfg_wr_data, opt_sel_rst} = 41'h2;
		{opt_sel_done, opt_sel_io, opt_capture, cfg_chain_mode, opt_userclk} = 9'h008;
		void'($urandom(5631));
		cfg_master = 1'($urandom);
		capture_values = 8'($urandom);
		foreach (mem[i])
			mem[i] = 8'($urandom);
		startup(3'h2, 1'b0, 1'b0, 3'h1);
		readout(1'b1, 999, 1'b0);
		startup(3'h3, 1'b1, 1'b0, 3'h2);
		readout(1'b0, 20, 1'b1);
		startup(3'h2, 1'b0, 1'b1, 3'h1);
		end_of_test();
	end
endmodule // cfsr_top_test
